// file: dsa_regs.vh
// Constants for the dual-slope converter sequencer: fields, counts and divider tables.
// Contract
// - At reset end sample chip-select strap once; high selects slave mode under host control.
// - Strap low selects master mode, reading 16-bit command words from serial EEPROM.
// - Slave mode without host runs from all-zero control: divide by 8, channel one.
// - Unconfigured device still streams valid results on the asynchronous output.
// - Reset clears every flip-flop and sets all internal registers to zero; the code loads phase_reg with PH_IDLE, 4'b0001.
// - Brownout indication also forces the reset condition.
// - Route temperature sensor when range is 250mV and unipolar bit is set.
// - Five control bits pick channel and range; three more plus mode pin pick dividers.
// - Converter step period is an integer multiple of the input clock period.
// - Conversion runs 1024 auto-zero, 1024 integrate, then 2048 reference steps.
// - Each result is readable in parallel and sent as two asynchronous characters; the code's second character carries the previous result's top nibble.
// - Ready output goes low at end of reference integration.
// - Result invalid once ready returns high; host must finish reading while low.
// - Ready state is mirrored in bit 7 of the upper result register.
// - Restart input held low gives continuous back-to-back conversions.
// - Restart rising edge forces sequencer immediately to start of auto-zero.
// - After restart falls, timing resumes on the next step clock edge.
// - Twelve-bit offset binary result: FFF full positive, 800/7FF around zero, 000.
// - Unipolar mode uses the same codes spanning zero to twice full scale.
// - Channel field 00 input one, 01 input three, 10 ground, 11 input two.
// - Range field 000 50mV, 001 25mV, 010 250mV, 011 10mV; top bit unipolar.
`ifndef DSA_REGS_VH
`define DSA_REGS_VH
`define DSA_CTRL_RESET 8'h00
`define DSA_CR_DIV_MSB 7
`define DSA_CR_DIV_LSB 5
`define DSA_CR_CH_MSB 4
`define DSA_CR_CH_LSB 3
`define DSA_CR_FS_MSB 2
`define DSA_CR_FS_LSB 0
`define DSA_FS_TEMP 3'h6
`define DSA_AZ_LAST 12'h3FF
`define DSA_INT_LAST 12'h3FF
`define DSA_REF_LAST 12'h7FF
`define DSA_RDY_LAST 12'h7FF
`define DSA_MAG_MAX 11'h7FF
`define DSA_ADIV_L 72'd0
`define DSA_EE_READ_OP 9'h180
`define DSA_EE_HALF 4'h4
`define DSA_EE_OUT_BITS 5'h09
`define DSA_EE_LAST_BIT 5'h19
`define DSA_STRAP_WAIT 2'h3
`define DSA_TX_BITS 5'h14
`endif

// file: dsa_sequencer.v
// Dual-slope converter sequencer with strap mode, EEPROM fetch and async result output.
`timescale 1ns/1ps
`include "dsa_regs.vh"
module dsa_sequencer (
  // Clock and reset.
  input wire REF_CLK,
  input wire RST_N,
  // Pins from outside the clock domain.
  input wire BROWNOUT_DET,
  input wire CS_STRAP,
  input wire RESTART_IN,
  input wire DIVIDER_MODE_SEL,
  input wire INTEG_ABOVE_ZERO,
  // Host control and read side, same clock domain.
  input wire CTRL_WR,
  input wire [7:0] CTRL_DATA,
  input wire RESULT_READ,
  output wire [7:0] RESULT_HI,
  output wire [7:0] RESULT_LO,
  output wire RESULT_READY_N,
  output wire MODE_MASTER,
  // Analog front-end steering.
  output wire [1:0] CHAN_SEL,
  output wire [2:0] RANGE_SEL,
  output wire TEMP_SEL,
  output wire AZ_ON,
  output wire INT_ON,
  output wire REF_ON,
  output wire REF_POL,
  // Serial EEPROM in master mode.
  output wire EE_CS,
  output wire EE_SCK,
  output wire EE_DI,
  input wire EE_DO,
  // Asynchronous result output.
  output wire ASYNC_RESULT_OUT
);

  localparam PH_IDLE = 4'b0001;
  localparam PH_AZ = 4'b0010;
  localparam PH_INT = 4'b0100;
  localparam PH_REF = 4'b1000;

  // Two-flop synchronisers; the first stage feeds only the second.
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  wire brown_s = sync2_reg[0];
  wire strap_s = sync2_reg[1];
  wire restart_s = sync2_reg[2];
  wire m1_s = sync2_reg[3];
  wire integ_s = sync2_reg[4];
  wire ee_do_s = sync2_reg[5];

  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {EE_DO, INTEG_ABOVE_ZERO, DIVIDER_MODE_SEL, RESTART_IN, CS_STRAP, BROWNOUT_DET};
      sync2_reg <= sync1_reg;
    end
  end

  // brownout forces reset. The synchroniser itself is spared so the level is seen.
  wire rst = !RST_N || brown_s;

  reg [1:0] strap_cnt_reg;
  reg strap_done_reg;
  reg master_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_pend_reg;
  reg [2:0] addr_reg;
  reg [2:0] cur_addr_reg;
  reg [8:0] div_cnt_reg;
  reg [3:0] phase_reg;
  reg [11:0] step_reg;
  reg pol_reg;
  reg crossed_reg;
  reg [10:0] mag_reg;
  reg [11:0] result_reg;
  reg rdy_reg;
  reg [11:0] rdy_cnt_reg;
  reg restart_d_reg;
  reg ee_req_reg;
  reg ee_busy_reg;
  reg [3:0] ee_div_reg;
  reg ee_sck_reg;
  reg [4:0] ee_bit_reg;
  reg [8:0] ee_out_reg;
  reg [15:0] ee_in_reg;
  reg tx_busy_reg;
  reg [19:0] tx_sh_reg;
  reg [4:0] tx_cnt_reg;
  reg [10:0] baud_cnt_reg;
  reg tx_low_reg;

  // divider ratios from three control bits and the mode pin.
  reg [8:0] adc_div;
  reg [10:0] baud_div;
  always @* begin
    case ({m1_s, ctrl_reg[`DSA_CR_DIV_MSB:`DSA_CR_DIV_LSB]})
      4'h0: begin adc_div = 9'h008; baud_div = 11'h200; end
      4'h1: begin adc_div = 9'h004; baud_div = 11'h100; end
      4'h2: begin adc_div = 9'h006; baud_div = 11'h180; end
      4'h3: begin adc_div = 9'h003; baud_div = 11'h0C0; end
      4'h4: begin adc_div = 9'h0C0; baud_div = 11'h400; end
      4'h5: begin adc_div = 9'h0D8; baud_div = 11'h480; end
      4'h6: begin adc_div = 9'h120; baud_div = 11'h600; end
      4'h7: begin adc_div = 9'h138; baud_div = 11'h680; end
      4'h8: begin adc_div = 9'h008; baud_div = 11'h1A0; end
      4'h9: begin adc_div = 9'h004; baud_div = 11'h0D0; end
      4'hA: begin adc_div = 9'h00C; baud_div = 11'h300; end
      4'hB: begin adc_div = 9'h00D; baud_div = 11'h340; end
      4'hC: begin adc_div = 9'h0A0; baud_div = 11'h400; end
      4'hD: begin adc_div = 9'h0B4; baud_div = 11'h480; end
      4'hE: begin adc_div = 9'h0F0; baud_div = 11'h600; end
      default: begin adc_div = 9'h104; baud_div = 11'h680; end
    endcase
  end

  // step tick every adc_div input clocks.
  wire step_tick = (div_cnt_reg == adc_div - 9'h001);
  wire restart_rise = restart_s && !restart_d_reg;
  wire ref_end = (phase_reg == PH_REF) && step_tick && (step_reg == `DSA_REF_LAST);
  wire conv_start = strap_done_reg && !restart_s && step_tick &&
                    ((phase_reg == PH_IDLE) || ref_end);

  // strap sampled once after the synchroniser has filled, then held.
  always @(posedge REF_CLK) begin
    if (rst) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `DSA_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        master_reg <= !strap_s;
      end
    end
  end

  // Control staging; new settings take effect only at a conversion start.
  always @(posedge REF_CLK) begin
    if (rst) begin
      ctrl_reg <= `DSA_CTRL_RESET;
      ctrl_pend_reg <= `DSA_CTRL_RESET;
      cur_addr_reg <= 3'h0;
    end else begin
      if (ee_busy_reg && ee_sck_reg && ee_div_reg == `DSA_EE_HALF &&
          ee_bit_reg == `DSA_EE_LAST_BIT)
        ctrl_pend_reg <= {ee_in_reg[6:0], ee_do_s};
      else if (!master_reg && CTRL_WR)
        ctrl_pend_reg <= CTRL_DATA;
      if (conv_start) begin
        ctrl_reg <= ctrl_pend_reg;
        cur_addr_reg <= addr_reg;
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (rst) begin
      div_cnt_reg <= 9'h000;
      phase_reg <= PH_IDLE;
      step_reg <= 12'h000;
      restart_d_reg <= 1'b0;
      pol_reg <= 1'b0;
      crossed_reg <= 1'b0;
      mag_reg <= 11'h000;
    end else begin
      restart_d_reg <= restart_s;
      div_cnt_reg <= (step_tick || restart_s) ? 9'h000 : div_cnt_reg + 9'h001;
      if (restart_rise || restart_s) begin
        // Held at the start of auto-zero while restart is high.
        phase_reg <= PH_IDLE;
        step_reg <= 12'h000;
      end else if (conv_start) begin
        phase_reg <= PH_AZ;
        step_reg <= 12'h000;
      end else if (step_tick) begin
        step_reg <= step_reg + 12'h001;
        case (phase_reg)
          PH_AZ: begin
            if (step_reg == `DSA_AZ_LAST) begin
              phase_reg <= PH_INT;
              step_reg <= 12'h000;
            end
          end
          PH_INT: begin
            if (step_reg == `DSA_INT_LAST) begin
              phase_reg <= PH_REF;
              step_reg <= 12'h000;
              pol_reg <= integ_s;
              crossed_reg <= 1'b0;
              mag_reg <= `DSA_MAG_MAX;
            end
          end
          PH_REF: begin
            // The first step at which the integrator crosses back sets the magnitude.
            if (!crossed_reg && integ_s != pol_reg) begin
              crossed_reg <= 1'b1;
              mag_reg <= step_reg[10:0];
            end
          end
          default: phase_reg <= PH_IDLE;
        endcase
      end
    end
  end

  // offset binary; a negative input counts down from 7FF.
  wire [11:0] code = pol_reg ? {1'b1, mag_reg} : {1'b0, ~mag_reg};

  // latch and ready. Set wins over a same-cycle read clear.
  always @(posedge REF_CLK) begin
    if (rst) begin
      result_reg <= 12'h000;
      rdy_reg <= 1'b0;
      rdy_cnt_reg <= 12'h000;
    end else if (ref_end) begin
      result_reg <= code;
      rdy_reg <= 1'b1;
      rdy_cnt_reg <= 12'h000;
    end else if (rdy_reg) begin
      if (step_tick)
        rdy_cnt_reg <= rdy_cnt_reg + 12'h001;
      if (RESULT_READ || restart_rise || (step_tick && rdy_cnt_reg == `DSA_RDY_LAST))
        rdy_reg <= 1'b0;
    end
  end

  // microwire read of one command word; address steps per conversion.
  always @(posedge REF_CLK) begin
    if (rst) begin
      ee_req_reg <= 1'b0;
      ee_busy_reg <= 1'b0;
      ee_div_reg <= 4'h0;
      ee_sck_reg <= 1'b0;
      ee_bit_reg <= 5'h00;
      ee_out_reg <= 9'h000;
      ee_in_reg <= 16'h0000;
      addr_reg <= 3'h0;
    end else begin
      if (restart_rise)
        addr_reg <= 3'h0;
      if (master_reg && ((strap_done_reg && !ee_req_reg && !ee_busy_reg &&
          phase_reg == PH_IDLE) || ref_end))
        ee_req_reg <= 1'b1;
      if (ee_req_reg && !ee_busy_reg) begin
        ee_req_reg <= 1'b0;
        ee_busy_reg <= 1'b1;
        ee_bit_reg <= 5'h00;
        ee_div_reg <= 4'h0;
        ee_sck_reg <= 1'b0;
        ee_out_reg <= `DSA_EE_READ_OP | {6'h00, addr_reg};
      end else if (ee_busy_reg) begin
        ee_div_reg <= ee_div_reg + 4'h1;
        if (ee_div_reg == `DSA_EE_HALF) begin
          ee_div_reg <= 4'h0;
          ee_sck_reg <= !ee_sck_reg;
          if (ee_sck_reg) begin
            // Falling edge: present next bit or finish.
            ee_bit_reg <= ee_bit_reg + 5'h01;
            ee_out_reg <= {ee_out_reg[7:0], 1'b0};
            if (ee_bit_reg >= `DSA_EE_OUT_BITS)
              ee_in_reg <= {ee_in_reg[14:0], ee_do_s};
            if (ee_bit_reg == `DSA_EE_LAST_BIT) begin
              ee_busy_reg <= 1'b0;
              ee_sck_reg <= 1'b0;
              addr_reg <= addr_reg + 3'h1;
            end
          end
        end
      end
    end
  end

  // two 10-bit frames per result; the line idles high via inversion.
  wire [7:0] tx_hi = {ctrl_reg[7], cur_addr_reg, result_reg[11:8]};
  always @(posedge REF_CLK) begin
    if (rst) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 20'h00000;
      tx_cnt_reg <= 5'h00;
      baud_cnt_reg <= 11'h000;
      tx_low_reg <= 1'b0;
    end else if (!tx_busy_reg) begin
      tx_low_reg <= 1'b0;
      if (ref_end) begin
        // A frame still in flight drops the new result; slow baud settings limit rate.
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= {1'b1, tx_hi, 1'b0, 1'b1, code[7:0], 1'b0};
        tx_cnt_reg <= 5'h00;
        baud_cnt_reg <= 11'h000;
      end
    end else begin
      tx_low_reg <= !tx_sh_reg[0];
      baud_cnt_reg <= baud_cnt_reg + 11'h001;
      if (baud_cnt_reg == baud_div - 11'h001) begin
        baud_cnt_reg <= 11'h000;
        tx_sh_reg <= {1'b1, tx_sh_reg[19:1]};
        tx_cnt_reg <= tx_cnt_reg + 5'h01;
        if (tx_cnt_reg == `DSA_TX_BITS - 5'h01)
          tx_busy_reg <= 1'b0;
      end
    end
  end

  // ready mirrored in bit 7 of the upper result.
  assign RESULT_HI = {rdy_reg, 3'h0, result_reg[11:8]};
  assign RESULT_LO = result_reg[7:0];
  assign RESULT_READY_N = !rdy_reg;
  assign MODE_MASTER = master_reg;
  // fields passed straight to the mux and gain stage.
  assign CHAN_SEL = ctrl_reg[`DSA_CR_CH_MSB:`DSA_CR_CH_LSB];
  assign RANGE_SEL = ctrl_reg[`DSA_CR_FS_MSB:`DSA_CR_FS_LSB];
  assign TEMP_SEL = (ctrl_reg[`DSA_CR_FS_MSB:`DSA_CR_FS_LSB] == `DSA_FS_TEMP);
  assign AZ_ON = (phase_reg == PH_AZ) || (phase_reg == PH_IDLE);
  assign INT_ON = (phase_reg == PH_INT);
  assign REF_ON = (phase_reg == PH_REF);
  assign REF_POL = pol_reg;
  assign EE_CS = ee_busy_reg;
  assign EE_SCK = ee_sck_reg;
  assign EE_DI = ee_out_reg[8];
  assign ASYNC_RESULT_OUT = !tx_low_reg;

endmodule // dsa_sequencer

// file: dsa_eeprom_model.sv
// Behavioural serial configuration EEPROM that answers the sequencer's read fetches.
`timescale 1ns/1ps
module dsa_eeprom_model (
  // Serial pins seen from the memory side.
  input wire cs,
  input wire sck,
  input wire di,
  output reg dout
);
  reg [4:0] cnt_reg;
  reg [5:0] addr_reg;
  reg [15:0] word;
  initial begin
    cnt_reg = 5'h00;
    addr_reg = 6'h00;
    dout = 1'b1;
  end
  // read word back.
  // Bits shift in on the rising clock; the answer changes on the rising clock too,
  // so it stands for a whole period around the master's falling-edge sample.
  always @(posedge sck) begin
    if (cs) begin
      if (cnt_reg < 5'h09) addr_reg = {addr_reg[4:0], di};
      cnt_reg = cnt_reg + 5'h01;
      word = {8'h5A, 3'b011, ~addr_reg[1:0], 3'b001};
      // The dummy zero lands one clock after the last address bit, then sixteen data bits.
      if (cnt_reg == 5'h0A) dout = 1'b0;
      else if (cnt_reg > 5'h0A && cnt_reg < 5'h1B) dout = word[5'h1A - cnt_reg];
    end
  end
  // A deselected memory floats its output; show the inverse so no stale value passes.
  always @(negedge cs) begin
    cnt_reg = 5'h00;
    dout = ~dout;
  end
endmodule // dsa_eeprom_model

// file: dsa_sequencer_properties.sv
// Concurrent checks on the sequencer's top-level ports.
`timescale 1ns/1ps
module dsa_sequencer_properties (
  // Clock, reset and pins.
  input wire REF_CLK,
  input wire RST_N,
  input wire BROWNOUT_DET,
  input wire RESTART_IN,
  input wire RESULT_READ,
  // Observed outputs.
  input wire [7:0] RESULT_HI,
  input wire [7:0] RESULT_LO,
  input wire RESULT_READY_N,
  input wire MODE_MASTER,
  input wire [2:0] RANGE_SEL,
  input wire TEMP_SEL,
  input wire AZ_ON,
  input wire INT_ON,
  input wire REF_ON,
  input wire EE_CS,
  input wire ASYNC_RESULT_OUT
);
  reg [3:0] up_reg;
  // Edges since release; the mode is only meaningful once the strap was sampled.
  always @(posedge REF_CLK) begin
    // A brownout restarts the strap sampling, so it restarts the count as well.
    if (!RST_N || BROWNOUT_DET) up_reg <= 4'h0;
    else if (up_reg != 4'hF) up_reg <= up_reg + 4'h1;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_restart_held; $rose(RESTART_IN) ##1 RESTART_IN [*6]; endsequence
  sequence s_idle; AZ_ON && !INT_ON && !REF_ON; endsequence
  property p_reset_vals;
    $rose(RST_N) |-> RESULT_READY_N && RESULT_HI == 8'h00 && ASYNC_RESULT_OUT && !EE_CS;
  endproperty
  property p_mirror; RESULT_HI[7] == !RESULT_READY_N; endproperty
  property p_read_clear; !RESULT_READY_N && RESULT_READ |=> RESULT_READY_N; endproperty
  property p_temp; TEMP_SEL == (RANGE_SEL == 3'h6); endproperty
  property p_mode_hold; up_reg > 4'h6 |-> $stable(MODE_MASTER); endproperty
  property p_slave_quiet; !MODE_MASTER && up_reg > 4'h6 |-> !EE_CS; endproperty
  property p_ready_at_ref; $fell(RESULT_READY_N) |-> $past(REF_ON); endproperty
  property p_int_order; $rose(INT_ON) |-> $past(AZ_ON); endproperty
  property p_ref_order; $rose(REF_ON) |-> $past(INT_ON); endproperty
  property p_restart; s_restart_held |-> s_idle; endproperty
  property p_brownout; BROWNOUT_DET [*4] |=> RESULT_READY_N && RESULT_LO == 8'h00; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_mirror: assert property (p_mirror) else $error("ready bit mismatch");
  a_read_clear: assert property (p_read_clear) else $error("read kept ready");
  a_temp: assert property (p_temp) else $error("temp select mismatch");
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove memory");
  a_ready_at_ref: assert property (p_ready_at_ref) else $error("ready not at ref");
  a_int_order: assert property (p_int_order) else $error("integrate order");
  a_ref_order: assert property (p_ref_order) else $error("reference order");
  a_restart: assert property (p_restart) else $error("restart not idle");
  a_brownout: assert property (p_brownout) else $error("brownout no reset");
endmodule // dsa_sequencer_properties
bind dsa_sequencer dsa_sequencer_properties u_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .BROWNOUT_DET(BROWNOUT_DET), .RESTART_IN(RESTART_IN),
  .RESULT_READ(RESULT_READ), .RESULT_HI(RESULT_HI), .RESULT_LO(RESULT_LO),
  .RESULT_READY_N(RESULT_READY_N), .MODE_MASTER(MODE_MASTER), .RANGE_SEL(RANGE_SEL),
  .TEMP_SEL(TEMP_SEL), .AZ_ON(AZ_ON), .INT_ON(INT_ON), .REF_ON(REF_ON), .EE_CS(EE_CS),
  .ASYNC_RESULT_OUT(ASYNC_RESULT_OUT));

// file: dsa_sequencer_test.sv
// Self-checking bench for the dual-slope sequencer with an EEPROM partner.
`timescale 1ns/1ps
`define CHK(N, E, A) begin cmp_count++; if ((A) !== (E)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", N, E, A); end end
module dsa_sequencer_test;
  reg REF_CLK = 1'b0;
  reg RST_N = 1'b0;
  reg BROWNOUT_DET = 1'b0;
  reg CS_STRAP = 1'b1;
  reg RESTART_IN = 1'b0;
  reg DIVIDER_MODE_SEL = 1'b0;
  reg INTEG_ABOVE_ZERO = 1'b1;
  reg CTRL_WR = 1'b0;
  reg RESULT_READ = 1'b0;
  reg [7:0] CTRL_DATA = 8'h00;
  wire [7:0] RESULT_HI;
  wire [7:0] RESULT_LO;
  wire [1:0] CHAN_SEL;
  wire [2:0] RANGE_SEL;
  wire RESULT_READY_N, MODE_MASTER, TEMP_SEL, AZ_ON, INT_ON, REF_ON, REF_POL;
  wire EE_CS, EE_SCK, EE_DI, EE_DO, ASYNC_RESULT_OUT;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer n;
  integer i;
  reg [11:0] exp_q [$];
  reg [11:0] e_val;
  reg [7:0] ctrl_b;
  reg [7:0] rx;
  dsa_sequencer DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .BROWNOUT_DET(BROWNOUT_DET),
    .CS_STRAP(CS_STRAP), .RESTART_IN(RESTART_IN), .DIVIDER_MODE_SEL(DIVIDER_MODE_SEL),
    .INTEG_ABOVE_ZERO(INTEG_ABOVE_ZERO), .CTRL_WR(CTRL_WR), .CTRL_DATA(CTRL_DATA),
    .RESULT_READ(RESULT_READ), .RESULT_HI(RESULT_HI), .RESULT_LO(RESULT_LO),
    .RESULT_READY_N(RESULT_READY_N), .MODE_MASTER(MODE_MASTER), .CHAN_SEL(CHAN_SEL),
    .RANGE_SEL(RANGE_SEL), .TEMP_SEL(TEMP_SEL), .AZ_ON(AZ_ON), .INT_ON(INT_ON), .REF_ON(REF_ON),
    .REF_POL(REF_POL), .EE_CS(EE_CS), .EE_SCK(EE_SCK), .EE_DI(EE_DI), .EE_DO(EE_DO),
    .ASYNC_RESULT_OUT(ASYNC_RESULT_OUT));
  dsa_eeprom_model u_ee (.cs(EE_CS), .sck(EE_SCK), .di(EE_DI), .dout(EE_DO));
  // A 20 ns period clock.
  initial forever #10 REF_CLK = ~REF_CLK;
  task tick(input integer k); begin repeat (k) @(posedge REF_CLK); #1; end endtask
  task finish_test;
    begin
      // A noted result that never arrived counts as a mismatch.
      mismatches = mismatches + exp_q.size();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Bounded wait for a result; a hang ends the run as a failure.
  task wait_rdy(input integer lim);
    begin
      n = 0;
      while (RESULT_READY_N !== 1'b0 && n < lim) begin tick(1); n = n + 1; end
      if (n >= lim) begin mismatches++; $display("[FAIL] ready expected 0 seen 1"); finish_test; end
    end
  endtask
  task pulse_wr(input [7:0] d); begin CTRL_DATA = d; CTRL_WR = 1'b1; tick(1); CTRL_WR = 1'b0; end
  endtask
  // Bounded wait while the async line holds one level; n ends as the clocks spent.
  task wait_line(input v, input integer lim);
    begin
      n = 0;
      while (ASYNC_RESULT_OUT === v && n < lim) begin tick(1); n = n + 1; end
      if (n >= lim) begin
        mismatches++;
        $display("[FAIL] line expected %0h seen %0h", !v, v);
        finish_test;
      end
    end
  endtask
  // Receives the first character; divider code 011 gives 192 clocks a bit.
  task rx_byte;
    begin
      wait_line(1'b1, 100);
      tick(96);
      for (i = 0; i < 8; i = i + 1) begin tick(192); rx[i] = ASYNC_RESULT_OUT; end
    end
  endtask
  // Each falling ready takes the oldest noted result, if one was noted.
  always @(negedge RESULT_READY_N) begin
    #2;
    if (exp_q.size() > 0) begin
      e_val = exp_q.pop_front();
      `CHK("result", e_val, {RESULT_HI[3:0], RESULT_LO})
      `CHK("ready bit", 1'b1, RESULT_HI[7])
    end
  end
  // Main sequence: slave runs, restart, brownout, then master fetch.
  initial begin
    n = $urandom(32'hF4E62863);
    tick(10);
    RST_N = 1'b1;
    tick(1);
    `CHK("ready", 1'b1, RESULT_READY_N)
    `CHK("hi", 8'h00, RESULT_HI)
    `CHK("async", 1'b1, ASYNC_RESULT_OUT)
    `CHK("chan", 2'h0, CHAN_SEL)
    `CHK("range", 3'h0, RANGE_SEL)
    pulse_wr(8'h7E);
    tick(6);
    `CHK("mode", 1'b0, MODE_MASTER)
    exp_q.push_back(12'hFFF);
    wait_rdy(13000);
    `CHK("chan", 2'h3, CHAN_SEL)
    `CHK("range", 3'h6, RANGE_SEL)
    `CHK("temp", 1'b1, TEMP_SEL)
    `CHK("pol", 1'b1, REF_POL)
    RESULT_READ = 1'b1;
    tick(1);
    RESULT_READ = 1'b0;
    `CHK("ready after read", 1'b1, RESULT_READY_N)
    n = $urandom;
    ctrl_b = {3'b011, n[4:0]};
    pulse_wr(ctrl_b);
    INTEG_ABOVE_ZERO = 1'b0;
    exp_q.push_back(12'h000);
    $display("test slave codes done");
    wait_rdy(13000);
    `CHK("pol", 1'b0, REF_POL)
    rx_byte;
    `CHK("async low byte", 8'h00, rx)
    tick(192);
    `CHK("stop bit", 1'b1, ASYNC_RESULT_OUT)
    `CHK("chan", ctrl_b[4:3], CHAN_SEL)
    `CHK("range", ctrl_b[2:0], RANGE_SEL)
    `CHK("temp", ctrl_b[2:0] == 3'h6, TEMP_SEL)
    $display("test async and control done");
    tick(2500);
    `CHK("integrating", 1'b1, INT_ON)
    RESTART_IN = 1'b1;
    tick(8);
    `CHK("az on", 1'b1, AZ_ON)
    `CHK("int off", 1'b0, INT_ON)
    `CHK("ready cleared", 1'b1, RESULT_READY_N)
    tick(40);
    INTEG_ABOVE_ZERO = 1'b1;
    RESTART_IN = 1'b0;
    exp_q.push_back(12'hFFF);
    wait_rdy(12400);
    `CHK("conv length", 1'b1, n >= 12284 && n <= 12300)
    $display("test restart done");
    tick(100);
    BROWNOUT_DET = 1'b1;
    tick(6);
    `CHK("ready", 1'b1, RESULT_READY_N)
    `CHK("lo", 8'h00, RESULT_LO)
    `CHK("async", 1'b1, ASYNC_RESULT_OUT)
    BROWNOUT_DET = 1'b0;
    tick(10);
    $display("test brownout done");
    RST_N = 1'b0;
    CS_STRAP = 1'b0;
    DIVIDER_MODE_SEL = 1'b1;
    tick(10);
    RST_N = 1'b1;
    tick(8);
    `CHK("mode", 1'b1, MODE_MASTER)
    CS_STRAP = 1'b1;
    tick(400);
    pulse_wr(8'h00);
    exp_q.push_back(12'hFFF);
    wait_rdy(33500);
    wait_line(1'b1, 100);
    wait_line(1'b0, 2000);
    `CHK("start bit clocks", 832, n)
    tick(20);
    `CHK("chan", 2'h3, CHAN_SEL)
    `CHK("range", 3'h1, RANGE_SEL)
    `CHK("mode held", 1'b1, MODE_MASTER)
    $display("test master done");
    finish_test;
  end
endmodule // dsa_sequencer_test
